// [rtl/lpm_line_loop.sv]
// Line loop mode select, video identification and comparator inhibit logic
//
// The placing of the registers and the APB slave port were decided locally.
`timescale 1ns/1ps
`default_nettype none
//
// Operation
// - Low on the VCR-mode input selects short time constant.
// - No video present also selects short time constant to speed capture.
// - Mode changes comparator current amplitude, never filter parts.
// - Video detected by sync coinciding with a fixed 2 us window.
// - Window generated once per line, centred on sync when locked.
// - Coincidence level becomes video flag through hysteresis comparator.
// - Video recognition status is an output for muting and tuning.
// - Comparator disabled while frame retrace inhibit is active.
// - Comparator also disabled during extracted frame sync.
// - Long mode inhibits line trace except frame lines 8 to 21.
// - Long inhibit: mute AND (retrace OR fsync OR (NOT blank AND trace gate)).
// - Short mode drops line trace term, keeps retrace and fsync gated by mute.
// - Sawtooth reset once every 32 oscillator periods.
// - Without video the line free-runs from the divided oscillator.
module lpm_line_loop
  import lpm_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst_b,
  input  wire logic        vcr_mode_b,
  input  wire logic        line_sync,
  input  wire logic        frame_retrace_inhibit,
  input  wire logic        extracted_frame_sync,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic             pslverr,
  output logic [31:0]      prdata,
  output logic             short_mode,
  output logic [1:0]       comp_amplitude,
  output logic             comp_inhibit,
  output logic             sawtooth_reset,
  output logic             id_window,
  output logic             line_blanking_window,
  output logic             line_trace_gate,
  output logic             video_present,
  output logic             irq
);
  // Reset release and pin synchronisers
  logic       rst_s1_reg, rst_s2_reg;
  logic       rst_s1_next, rst_s2_next;
  logic [3:0] pin_s1_reg, pin_s2_reg;
  logic [3:0] pin_s1_next, pin_s2_next;
  logic       rst_i;

  // Reset asserts at once but is released on a clock edge, two stages deep
  always_comb begin
    rst_s1_next = 1'b1;
    rst_s2_next = rst_s1_reg;
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rst_s1_reg <= 1'b0;
      rst_s2_reg <= 1'b0;
    end else begin
      rst_s1_reg <= rst_s1_next;
      rst_s2_reg <= rst_s2_next;
    end
  end
  assign rst_i = rst_s2_reg;

  // Pins come from outside the clock domain; first stage feeds only the second
  always_comb begin
    pin_s1_next = {extracted_frame_sync, frame_retrace_inhibit, line_sync, vcr_mode_b};
    pin_s2_next = pin_s1_reg;
  end

  // Idle levels after reset: vcr input high, sync and frame pins low
  always_ff @(posedge clock or negedge rst_i) begin
    if (!rst_i) begin
      pin_s1_reg <= 4'h1;
      pin_s2_reg <= 4'h1;
    end else begin
      pin_s1_reg <= pin_s1_next;
      pin_s2_reg <= pin_s2_next;
    end
  end

  // Only the second stage of each synchroniser is read from here on
  logic vcr_b_s, sync_s, fri_s, fs_s;
  assign vcr_b_s = pin_s2_reg[0];
  assign sync_s  = pin_s2_reg[1];
  assign fri_s   = pin_s2_reg[2];
  assign fs_s    = pin_s2_reg[3];

  // Oscillator timing: tick divider, line phase and line count
  logic [4:0] tick_reg, tick_next;
  logic [4:0] phase_reg, phase_next;
  logic [9:0] lcnt_reg, lcnt_next;
  logic       fs_d_reg, fs_d_next;
  logic       osc_tick, line_end, frame_start;

  assign osc_tick    = (tick_reg == TICK_LAST);
  assign line_end    = osc_tick && (phase_reg == LINE_PHASE_MAX);
  assign frame_start = fs_s && !fs_d_reg;

  // Free-running divider: line period is 32 oscillator periods whether locked or not
  always_comb begin
    tick_next  = osc_tick ? 5'h00 : tick_reg + 5'h01;
    phase_next = phase_reg;
    lcnt_next  = lcnt_reg;
    fs_d_next  = fs_s;
    if (osc_tick) begin
      phase_next = (phase_reg == LINE_PHASE_MAX) ? 5'h00 : phase_reg + 5'h01;
    end
    // Count saturates so a missing frame sync never wraps into the gate-free lines
    if (frame_start) begin
      lcnt_next = 10'h000;
    end else if (line_end && lcnt_reg != 10'h3ff) begin
      lcnt_next = lcnt_reg + 10'h001;
    end
  end

  always_ff @(posedge clock or negedge rst_i) begin
    if (!rst_i) begin
      tick_reg  <= 5'h00;
      phase_reg <= 5'h00;
      lcnt_reg  <= 10'h000;
      fs_d_reg  <= 1'b0;
    end else begin
      tick_reg  <= tick_next;
      phase_reg <= phase_next;
      lcnt_reg  <= lcnt_next;
      fs_d_reg  <= fs_d_next;
    end
  end

  // Window around the line start, where a locked loop places the sync centre
  logic win_c, blank_c, trace_c, in_free_lines;
  assign win_c         = (phase_reg - WIN_START) < WIN_LEN;
  assign blank_c       = phase_reg < BLANK_END;
  assign trace_c       = !blank_c;
  assign in_free_lines = (lcnt_reg >= GATE_FREE_FIRST) && (lcnt_reg <= GATE_FREE_LAST);

  // Video flag from the coincidence integrator
  logic [7:0] vid_level;
  logic       vid_present_w;

  lpm_video_ident u_ident (
    .clock         (clock),
    .rst_b         (rst_i),
    .line_end      (line_end),
    .window        (win_c),
    .sync_in       (sync_s),
    .video_present (vid_present_w),
    .level         (vid_level)
  );

  // Registers: control, interrupt status and mask
  logic [2:0] ctrl_reg, ctrl_next;
  logic [2:0] ist_reg, ist_next;
  logic [2:0] imask_reg, imask_next;
  logic [31:0] rdata_reg, rdata_next;
  logic       vid_d_reg, mode_d_reg, vid_d_next, short_d_next;
  logic       short_c, mute_c, inh_c;
  logic       wr_en, rd_en, addr_ok;
  logic [2:0] events;

  // Software may force short mode (bit0) or lift the comparator gating (bit1)
  assign short_c = !vcr_b_s || !vid_present_w || ctrl_reg[0];
  // Without video the gating is off, so the loop can capture any sync it finds
  assign mute_c  = vid_present_w && !ctrl_reg[1];

  // Frame terms apply in both modes; the line term only in long mode
  logic frame_term_c, line_term_c;
  assign frame_term_c = fri_s || fs_s;
  assign line_term_c  = !blank_c && trace_c && !in_free_lines;

  // Comparator gating: short mode drops the line trace term
  always_comb begin
    if (short_c) begin
      inh_c = mute_c && frame_term_c;
    end else begin
      inh_c = mute_c && (frame_term_c || line_term_c);
    end
  end

  // Writes land in the access phase; reads are captured at setup
  assign wr_en   = psel && penable && pwrite;
  assign rd_en   = psel && !penable && !pwrite;
  // One select per mapped register; any other offset answers with an error
  logic sel_ctrl, sel_status, sel_ist, sel_mask, sel_line;
  assign sel_ctrl   = (paddr == OFS_CTRL);
  assign sel_status = (paddr == OFS_STATUS);
  assign sel_ist    = (paddr == OFS_IRQ_STAT);
  assign sel_mask   = (paddr == OFS_IRQ_MASK);
  assign sel_line   = (paddr == OFS_LINE);
  assign addr_ok    = sel_ctrl || sel_status || sel_ist || sel_mask || sel_line;
  // Events: video gained, video lost, mode changed
  assign events  = {short_c != mode_d_reg, vid_d_reg && !vid_present_w, !vid_d_reg && vid_present_w};
  assign short_d_next = short_c;
  assign vid_d_next   = vid_present_w;

  // Register next values; a new event wins over a write-one clear
  always_comb begin
    ctrl_next  = ctrl_reg;
    imask_next = imask_reg;
    ist_next   = ist_reg;
    rdata_next = rdata_reg;
    if (wr_en && sel_ctrl) ctrl_next  = pwdata[2:0];
    if (wr_en && sel_mask) imask_next = pwdata[2:0];
    if (wr_en && sel_ist)  ist_next   = ist_reg & ~pwdata[2:0];
    ist_next = ist_next | events;
    if (rd_en) begin
      case (paddr)
        OFS_CTRL:     rdata_next = {29'h0, ctrl_reg};
        OFS_STATUS:   rdata_next = {20'h0, vid_level, 1'b0, inh_c, short_c, vid_present_w};
        OFS_IRQ_STAT: rdata_next = {29'h0, ist_reg};
        OFS_IRQ_MASK: rdata_next = {29'h0, imask_reg};
        OFS_LINE:     rdata_next = {17'h0, phase_reg, lcnt_reg};
        default:      rdata_next = 32'h0;
      endcase
    end
  end

  // Edge memories start at the idle levels of what they watch
  always_ff @(posedge clock or negedge rst_i) begin
    if (!rst_i) begin
      ctrl_reg   <= CTRL_RESET;
      imask_reg  <= MASK_RESET;
      ist_reg    <= 3'h0;
      rdata_reg  <= 32'h0;
      vid_d_reg  <= 1'b0;
      mode_d_reg <= 1'b1;
    end else begin
      ctrl_reg   <= ctrl_next;
      imask_reg  <= imask_next;
      ist_reg    <= ist_next;
      rdata_reg  <= rdata_next;
      vid_d_reg  <= vid_d_next;
      mode_d_reg <= short_d_next;
    end
  end

  // Outputs: mode selects current amplitude only; the filter is left alone
  logic       short_o_reg, inh_o_reg, saw_o_reg, win_o_reg, blk_o_reg, gate_o_reg, vid_o_reg;
  logic [1:0] amp_o_reg;
  logic       short_o_next, inh_o_next, saw_o_next, win_o_next, blk_o_next, gate_o_next, vid_o_next;
  logic [1:0] amp_o_next;

  // Every loop output leaves a flip-flop so its pin never sees decode glitches; irq, pready and pslverr do not
  always_comb begin
    short_o_next = short_c;
    amp_o_next   = inh_c ? AMP_OFF : (short_c ? AMP_SHORT : AMP_LONG);
    inh_o_next   = inh_c;
    saw_o_next   = line_end;
    win_o_next   = win_c;
    blk_o_next   = blank_c;
    gate_o_next  = trace_c && !in_free_lines;
    vid_o_next   = vid_present_w;
  end

  always_ff @(posedge clock or negedge rst_i) begin
    if (!rst_i) begin
      short_o_reg <= 1'b1;
      amp_o_reg   <= AMP_OFF;
      inh_o_reg   <= 1'b1;
      saw_o_reg   <= 1'b0;
      win_o_reg   <= 1'b0;
      blk_o_reg   <= 1'b0;
      gate_o_reg  <= 1'b0;
      vid_o_reg   <= 1'b0;
    end else begin
      short_o_reg <= short_o_next;
      amp_o_reg   <= amp_o_next;
      inh_o_reg   <= inh_o_next;
      saw_o_reg   <= saw_o_next;
      win_o_reg   <= win_o_next;
      blk_o_reg   <= blk_o_next;
      gate_o_reg  <= gate_o_next;
      vid_o_reg   <= vid_o_next;
    end
  end

  assign short_mode           = short_o_reg;
  assign comp_amplitude       = amp_o_reg;
  assign comp_inhibit         = inh_o_reg;
  assign sawtooth_reset       = saw_o_reg;
  assign id_window            = win_o_reg;
  assign line_blanking_window = blk_o_reg;
  assign line_trace_gate      = gate_o_reg;
  assign video_present        = vid_o_reg;

  // Level interrupt, high while any unmasked event bit stays set
  assign irq                  = |(ist_reg & imask_reg);
  // Setup-phase read capture lets every access finish in one access cycle
  assign pready               = psel && penable;
  assign pslverr              = psel && penable && !addr_ok;
  assign prdata               = rdata_reg;
endmodule
`default_nettype wire

// [rtl/lpm_pkg.sv]
// Package of constants and types for the line loop mode and inhibit logic
package lpm_pkg;
  // Oscillator periods per line; the sawtooth reset marks the line boundary
  localparam int unsigned OSC_PER_LINE     = 32;
  localparam logic [4:0]  LINE_PHASE_MAX   = 5'h1f;
  // Identification window: 2 us at 500 kHz oscillator = 1 period, centred on sync
  localparam int unsigned WIN_US           = 2;
  localparam int unsigned OSC_PERIOD_NS    = 2000;
  localparam int unsigned WIN_PERIODS      = (WIN_US * 1000) / OSC_PERIOD_NS;
  localparam logic [4:0]  WIN_START        = 5'h00;
  localparam logic [4:0]  WIN_LEN          = 5'h01;
  // Blanking window in oscillator periods from line start
  localparam logic [4:0]  BLANK_END        = 5'h06;
  // Lines at frame start where line trace gating is lifted
  localparam logic [9:0]  GATE_FREE_FIRST  = 10'h008;
  localparam logic [9:0]  GATE_FREE_LAST   = 10'h015;
  // Coincidence integrator and hysteresis thresholds
  localparam logic [7:0]  ACC_MAX          = 8'hff;
  localparam logic [7:0]  ACC_RESET        = 8'h00;
  localparam logic [7:0]  THR_HIGH         = 8'hc0;
  localparam logic [7:0]  THR_LOW          = 8'h40;
  localparam logic [7:0]  ACC_UP           = 8'h08;
  localparam logic [7:0]  ACC_DOWN         = 8'h01;
  // Comparator current amplitude codes
  localparam logic [1:0]  AMP_OFF          = 2'h0;
  localparam logic [1:0]  AMP_LONG         = 2'h1;
  localparam logic [1:0]  AMP_SHORT        = 2'h3;
  // Oscillator tick divider: 10 MHz clock, 100 ns
  localparam int unsigned CLK_PERIOD_NS    = 100;
  localparam int unsigned TICK_DIV         = OSC_PERIOD_NS / CLK_PERIOD_NS;
  localparam logic [4:0]  TICK_LAST        = 5'(TICK_DIV - 1);
  // APB register offsets
  localparam logic [7:0]  OFS_CTRL         = 8'h00;
  localparam logic [7:0]  OFS_STATUS       = 8'h04;
  localparam logic [7:0]  OFS_IRQ_STAT     = 8'h08;
  localparam logic [7:0]  OFS_IRQ_MASK     = 8'h0c;
  localparam logic [7:0]  OFS_LINE         = 8'h10;
  localparam logic [2:0]  CTRL_RESET       = 3'h0;
  localparam logic [2:0]  MASK_RESET       = 3'h0;
  typedef enum logic [1:0] {
    LPM_VID_ABSENT  = 2'b00,
    LPM_VID_PRESENT = 2'b01
  } lpm_vid_t;
endpackage

// [rtl/lpm_video_ident.sv]
// Video identification: window coincidence integrator with hysteresis
`timescale 1ns/1ps
`default_nettype none
module lpm_video_ident
  import lpm_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       rst_b,
  input  wire logic       line_end,
  input  wire logic       window,
  input  wire logic       sync_in,
  output logic            video_present,
  output logic [7:0]      level
);
  lpm_vid_t   state_reg, state_next;
  logic [7:0] acc_reg, acc_next;
  logic       hit_reg, hit_next;

  // Latch any sync in window during the line, update integrator at line end
  always_comb begin
    hit_next   = hit_reg;
    acc_next   = acc_reg;
    state_next = state_reg;
    if (window && sync_in) begin
      hit_next = 1'b1;
    end
    if (line_end) begin
      hit_next = 1'b0;
      if (hit_reg || (window && sync_in)) begin
        acc_next = (acc_reg > ACC_MAX - ACC_UP) ? ACC_MAX : acc_reg + ACC_UP;
      end else begin
        acc_next = (acc_reg < ACC_DOWN) ? ACC_RESET : acc_reg - ACC_DOWN;
      end
    end
    // Two thresholds keep the flag steady on marginal signals
    case (state_reg)
      LPM_VID_ABSENT:  if (acc_reg >= THR_HIGH) state_next = LPM_VID_PRESENT;
      LPM_VID_PRESENT: if (acc_reg <= THR_LOW) state_next = LPM_VID_ABSENT;
      default:         state_next = LPM_VID_ABSENT;
    endcase
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= LPM_VID_ABSENT;
      acc_reg   <= ACC_RESET;
      hit_reg   <= 1'b0;
    end else begin
      state_reg <= state_next;
      acc_reg   <= acc_next;
      hit_reg   <= hit_next;
    end
  end

  assign video_present = (state_reg == LPM_VID_PRESENT);
  assign level         = acc_reg;
endmodule
`default_nettype wire

// [tb/lpm_line_loop_sva.sv]
// Checker of mode, inhibit and line timing outputs
`timescale 1ns/1ps
`default_nettype none
module lpm_line_loop_chk
  import lpm_pkg::*;
(
  input wire logic       clock,
  input wire logic       rst_b,
  input wire logic       vcr_mode_b,
  input wire logic       frame_retrace_inhibit,
  input wire logic       extracted_frame_sync,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pready,
  input wire logic       short_mode,
  input wire logic [1:0] comp_amplitude,
  input wire logic       comp_inhibit,
  input wire logic       sawtooth_reset,
  input wire logic       id_window,
  input wire logic       line_blanking_window,
  input wire logic       line_trace_gate,
  input wire logic       video_present
);
  logic [3:0] up_reg;
  logic       seen_reg;
  logic [9:0] gap_reg;
  logic [4:0] win_reg;
  wire logic  ok = (up_reg == 4'h8);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  // Settle count covers the pin synchronisers; gap and window lengths in clocks
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      up_reg   <= 4'h0;
      seen_reg <= 1'b0;
      gap_reg  <= 10'h000;
      win_reg  <= 5'h00;
    end else begin
      up_reg   <= ok ? up_reg : up_reg + 4'h1;
      seen_reg <= seen_reg | sawtooth_reset;
      gap_reg  <= sawtooth_reset ? 10'h000 : gap_reg + 10'h001;
      win_reg  <= id_window ? win_reg + 5'h01 : 5'h00;
    end
  end
  vcr_short_a: assert property ((ok && !vcr_mode_b) [*4] |-> short_mode)
    else $error("short mode missing with vcr input low");
  mute_short_a: assert property ((ok && !video_present) [*4] |-> short_mode)
    else $error("short mode missing without video");
  long_sel_a: assert property ((ok && vcr_mode_b && video_present) [*4] |-> !short_mode)
    else $error("short mode without cause");
  amp_code_a: assert property (ok && $stable(comp_inhibit) && $stable(short_mode)
    |-> comp_amplitude == (comp_inhibit ? AMP_OFF : (short_mode ? AMP_SHORT : AMP_LONG)))
    else $error("amplitude code does not follow mode");
  retrace_inh_a: assert property ((ok && frame_retrace_inhibit && video_present) [*4] |-> comp_inhibit)
    else $error("comparator live in frame retrace");
  fsync_inh_a: assert property ((ok && extracted_frame_sync && video_present) [*4] |-> comp_inhibit)
    else $error("comparator live in frame sync");
  trace_inh_a: assert property ((ok && !short_mode && video_present && line_trace_gate) [*3]
    |-> comp_inhibit) else $error("comparator live in long mode line trace");
  short_free_a: assert property ((ok && short_mode && !frame_retrace_inhibit
    && !extracted_frame_sync) [*4] |-> !comp_inhibit) else $error("short mode inhibit in line trace");
  saw_period_a: assert property (seen_reg && sawtooth_reset |-> gap_reg == 10'd639)
    else $error("sawtooth period wrong");
  win_len_a: assert property ($fell(id_window) |-> win_reg == 5'd20)
    else $error("window length wrong");
  gate_blank_a: assert property (line_trace_gate |-> !line_blanking_window)
    else $error("trace gate inside blanking");
  apb_ready_a: assert property (pready == (psel && penable))
    else $error("ready not zero wait");
  novid_free_a: assert property (ok && !video_present |-> !comp_inhibit)
    else $error("comparator inhibited without video");
endmodule
bind lpm_line_loop lpm_line_loop_chk chk (.clock, .rst_b, .vcr_mode_b, .frame_retrace_inhibit,
  .extracted_frame_sync, .psel, .penable, .pready, .short_mode, .comp_amplitude, .comp_inhibit,
  .sawtooth_reset, .id_window, .line_blanking_window, .line_trace_gate, .video_present);
`default_nettype wire

// [tb/lpm_line_loop_tb.sv]
// Self-checking bench of the line loop mode and inhibit block
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, x) begin num_checks++; if ((g) !== (x)) begin n_fail++; \
  $display("[FAIL] %0t got %h exp %h", $time, g, x); end end
module lpm_line_loop_tb
  import lpm_pkg::*;
;
  logic clock = 1'b0;
  logic rst_b, vcr_mode_b, frame_retrace_inhibit, extracted_frame_sync, video_on, e;
  logic psel, penable, pwrite, pready, pslverr, short_mode, comp_inhibit, sawtooth_reset;
  logic id_window, line_blanking_window, line_trace_gate, video_present, irq, line_sync;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q;
  logic [1:0]  comp_amplitude;
  int n_fail = 0, num_checks = 0, lines = 0, n, i;
  int tgt [4] = '{7, 8, 21, 22};
  always #50 clock = ~clock;
  lpm_line_loop dut (.clock, .rst_b, .vcr_mode_b, .line_sync, .frame_retrace_inhibit,
    .extracted_frame_sync, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr,
    .prdata, .short_mode, .comp_amplitude, .comp_inhibit, .sawtooth_reset, .id_window,
    .line_blanking_window, .line_trace_gate, .video_present, .irq);
  lpm_sync_model sep (.clock, .sawtooth_reset, .video_on, .line_sync);
  // Trace gate expected from the line count after a frame sync edge
  function automatic logic gate_exp(int l);
    return !(l >= int'(GATE_FREE_FIRST) && l <= int'(GATE_FREE_LAST));
  endfunction
  // One APB transfer; an idle edge first so strobes never change twice at once
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge clock); n++; end while (pready !== 1'b1 && n < 50);
    if (n >= 50) n_fail++;
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock); // Callers then see what the access edge wrote
  endtask
  task automatic wait_saw;
    @(posedge clock);
    while (sawtooth_reset !== 1'b1) @(posedge clock);
  endtask
  task automatic wrap_up;
    $display("checks %0d failures %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Watchdog sized well above the expected 31k clocks
  initial begin #8000000; n_fail++; wrap_up; end
  initial begin
    void'($urandom(32'h2144));
    rst_b = 0; vcr_mode_b = 1; frame_retrace_inhibit = 0; extracted_frame_sync = 0;
    psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; video_on = 0;
    repeat (12) @(posedge clock);
    rst_b <= 1'b1;
    repeat (3) @(posedge clock);
    apb(0, OFS_CTRL, 0); `CHK(q[2:0], CTRL_RESET)
    apb(0, OFS_IRQ_MASK, 0); `CHK(q[2:0], MASK_RESET)
    apb(0, 8'h20, 0); `CHK({e, q}, 33'h100000000)
    `CHK(short_mode, 1'b1)
    apb(1, OFS_IRQ_MASK, 32'h1);
    video_on <= 1'b1;
    n = 0;
    while (video_present !== 1'b1 && n < 40000) begin @(posedge clock); n++; end
    `CHK(video_present, 1'b1)
    `CHK(irq, 1'b1)
    apb(0, OFS_STATUS, 0); `CHK(q[1:0], 2'b01)
    apb(1, OFS_IRQ_STAT, 32'h7); `CHK(irq, 1'b0)
    // Frame sync just after a line start, so no line end races the count restart
    wait_saw;
    extracted_frame_sync <= 1'b1;
    repeat (8) @(posedge clock);
    extracted_frame_sync <= 1'b0;
    foreach (tgt[k]) begin
      while (lines < tgt[k]) begin wait_saw; lines++; end
      repeat (320) @(posedge clock);
      `CHK(line_trace_gate, gate_exp(tgt[k]))
      `CHK(comp_inhibit, gate_exp(tgt[k]))
      apb(0, OFS_LINE, 0); `CHK(q[9:0], 10'(tgt[k]))
    end
    // Random mode and frame pulses, first pass forced into vcr mode
    for (i = 0; i < 12; i++) begin
      vcr_mode_b <= (i == 0) ? 1'b0 : 1'($urandom % 2);
      frame_retrace_inhibit <= 1'($urandom % 2);
      extracted_frame_sync <= 1'($urandom % 3 == 0);
      repeat (6 + $urandom % 30) @(posedge clock);
      `CHK(short_mode, ~vcr_mode_b)
      if (frame_retrace_inhibit || extracted_frame_sync) begin
        `CHK({comp_inhibit, comp_amplitude}, {1'b1, AMP_OFF})
      end else if (!vcr_mode_b) begin
        `CHK({comp_inhibit, comp_amplitude}, {1'b0, AMP_SHORT})
      end
    end
    // Mode change event: masked, then unmasked, then cleared
    apb(1, OFS_IRQ_MASK, 32'h0); `CHK(irq, 1'b0)
    apb(0, OFS_IRQ_STAT, 0); `CHK(q[2], 1'b1)
    apb(1, OFS_IRQ_MASK, 32'h4); `CHK(irq, 1'b1)
    vcr_mode_b <= 1'b1;
    frame_retrace_inhibit <= 1'b0;
    extracted_frame_sync <= 1'b0;
    repeat (8) @(posedge clock);
    apb(1, OFS_IRQ_STAT, 32'h7); `CHK(irq, 1'b0)
    wrap_up;
  end
endmodule
`default_nettype wire

// [tb/lpm_sync_model.sv]
// Sync separator model: line sync around each line start
`timescale 1ns/1ps
`default_nettype none
module lpm_sync_model (
  input  wire logic clock,
  input  wire logic sawtooth_reset,
  input  wire logic video_on,
  output logic      line_sync
);
  logic [9:0] ph_reg = 10'h000;
  // Phase since line start, as a locked first loop would see it
  always_ff @(posedge clock) begin
    ph_reg <= sawtooth_reset ? 10'h000 : ph_reg + 10'h001;
  end
  // Sync straddles the window with margin for pin latency; low without video
  assign line_sync = video_on && (ph_reg < 10'd28 || ph_reg > 10'd630);
endmodule
`default_nettype wire
